/* File: verilog/bps_top.sv */
`timescale 1ns/1ps
`include "bps_defines.svh"

module bps_top import bps_pkg::*; #(
	parameter int STRAP_CYC = `BPS_STRAP_CYC,
	parameter int QTR_CYC = `BPS_I2C_QTR_CYC,
	parameter logic [7:0] SIG = 8'h5A, // arbitrary signature value
	parameter logic [15:0] VID_DEF = 16'h1234, // arbitrary vendor code
	parameter logic [15:0] PID_DEF = 16'h5678 // arbitrary product code
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// usb state from the same clock domain
	input wire logic usb_suspend,
	input wire logic usb_configured,
	input wire logic usb_bus_reset,
	// power limit pin
	input wire logic limit_pin_in,
	output logic limit_pin_out,
	output logic limit_pin_oe,
	// i2c pins, open drain
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// configuration result
	output logic bus_power_limit_flag,
	output logic cfg_done,
	output logic eeprom_valid,
	output logic remote_wakeup_en,
	output logic self_powered,
	output logic [15:0] cfg_vendor_id,
	output logic [15:0] cfg_product_id,
	output logic [7:0] cfg_attr,
	output logic [7:0] cfg_max_power
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] pin_raw;
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic lim_s;
	logic sda_s;
	logic scl_s;

	assign pin_raw = {limit_pin_in, scl_in, sda_in};
	assign lim_s = sync2_r[2];
	assign scl_s = sync2_r[1];
	assign sda_s = sync2_r[0];

	// two flops per pin, only the second is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					sync1_r[gi] <= 1'b1;
					sync2_r[gi] <= 1'b1;
				end else if (clk_en) begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// ************************************************************
	// eeprom reader
	// ************************************************************
	logic ee_start_r;
	logic ee_busy;
	logic ee_done;
	logic ee_ok;
	logic [63:0] ee_data;

	bps_i2c_rd #(
		.QTR_CYC(QTR_CYC),
		.SIG(SIG)
	) u_rd (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.start(ee_start_r),
		.sda_in(sda_s),
		.sda_oe(sda_oe),
		.scl_oe(scl_oe),
		.busy(ee_busy),
		.done(ee_done),
		.ok(ee_ok),
		.data(ee_data)
	);

	// open-drain data value is always low, only the enables move
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sda_out <= 1'b0;
			scl_out <= 1'b0;
		end else if (clk_en) begin
			sda_out <= 1'b0;
			scl_out <= 1'b0;
		end
	end

	// ************************************************************
	// power-up configuration sequencer
	// ************************************************************
	bps_top_st_t st_r;
	logic [15:0] st_cnt_r;
	logic straps_hi;

	assign straps_hi = sda_s & scl_s;

	// eeprom byte picker
	function automatic logic [7:0] ee_byte(input logic [63:0] d,
			input int idx);
		ee_byte = d[idx*8 +: 8];
	endfunction

	// strap settle, optional eeprom read, then run
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= TS_STRAP;
			st_cnt_r <= 16'h0000;
			ee_start_r <= 1'b0;
			cfg_done <= 1'b0;
			eeprom_valid <= 1'b0;
			remote_wakeup_en <= 1'b0;
			self_powered <= 1'b0;
			cfg_vendor_id <= `BPS_ID_RST;
			cfg_product_id <= `BPS_ID_RST;
			cfg_attr <= `BPS_ATTR_DEF;
			cfg_max_power <= `BPS_MAXP_DEF;
		end else if (clk_en) begin
			ee_start_r <= 1'b0;
			case (st_r)
				TS_STRAP: begin
					st_cnt_r <= st_cnt_r + 16'h0001;
					// lines released by the reader while waiting
					if (st_cnt_r == 16'(STRAP_CYC - 1) && !ee_busy) begin
						if (straps_hi) begin
							st_r <= TS_EE;
							ee_start_r <= 1'b1;
						end else begin
							st_r <= TS_RUN;
							cfg_done <= 1'b1;
							cfg_vendor_id <= VID_DEF;
							cfg_product_id <= PID_DEF;
							remote_wakeup_en <= ~sda_s;
							self_powered <= scl_s;
							// invert before zero-extending, else upper bits flip
							cfg_attr <= `BPS_ATTR_BASE
								| ({7'h00, scl_s} << `BPS_ATTR_SELF_BIT)
								| ({7'h00, ~sda_s} << `BPS_ATTR_RWK_BIT);
							cfg_max_power <= `BPS_MAXP_DEF;
						end
					end
				end
				TS_EE: if (ee_done) begin
					st_r <= TS_RUN;
					cfg_done <= 1'b1;
					if (ee_ok) begin
						// signature matched, take the stored bytes
						eeprom_valid <= 1'b1;
						cfg_vendor_id <= {ee_byte(ee_data, `BPS_EE_VID_HI),
							ee_byte(ee_data, `BPS_EE_VID_LO)};
						cfg_product_id <= {ee_byte(ee_data, `BPS_EE_PID_HI),
							ee_byte(ee_data, `BPS_EE_PID_LO)};
						cfg_attr <= ee_byte(ee_data, `BPS_EE_ATTR);
						cfg_max_power <= ee_byte(ee_data, `BPS_EE_MAXP);
						remote_wakeup_en <=
							ee_data[`BPS_EE_ATTR*8 + `BPS_ATTR_RWK_BIT];
						self_powered <=
							ee_data[`BPS_EE_ATTR*8 + `BPS_ATTR_SELF_BIT];
					end else begin
						// eeprom ignored, both straps were high
						cfg_vendor_id <= VID_DEF;
						cfg_product_id <= PID_DEF;
						remote_wakeup_en <= 1'b0;
						self_powered <= 1'b1;
						cfg_attr <= `BPS_ATTR_BASE
							| (8'h01 << `BPS_ATTR_SELF_BIT);
						cfg_max_power <= `BPS_MAXP_DEF;
					end
				end
				TS_RUN: st_r <= TS_RUN;
				default: st_r <= TS_STRAP;
			endcase
		end
	end

	// ************************************************************
	// limit pin polarity strap
	// ************************************************************
	logic sampling_r;
	logic [15:0] samp_cnt_r;
	logic pol_r;

	// release the pin and take its level after reset or bus reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sampling_r <= 1'b1;
			samp_cnt_r <= 16'h0000;
			pol_r <= `BPS_POL_RST;
		end else if (clk_en) begin
			if (usb_bus_reset) begin
				sampling_r <= 1'b1;
				samp_cnt_r <= 16'h0000;
			end else if (sampling_r) begin
				samp_cnt_r <= samp_cnt_r + 16'h0001;
				if (samp_cnt_r == 16'(STRAP_CYC - 1)) begin
					sampling_r <= 1'b0;
					pol_r <= lim_s;
				end
			end
		end
	end

	// ************************************************************
	// power limit output
	// ************************************************************
	logic limit_need;

	// suspend always limits, unconfigured limits a high-power device
	assign limit_need = usb_suspend
		| ((cfg_max_power > `BPS_LOWPWR_MAX) & ~usb_configured);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus_power_limit_flag <= 1'b1;
			limit_pin_out <= `BPS_POL_RST;
			limit_pin_oe <= 1'b0;
		end else if (clk_en) begin
			bus_power_limit_flag <= limit_need;
			// asserted level follows the sampled polarity
			limit_pin_out <= limit_need ? pol_r : ~pol_r;
			limit_pin_oe <= ~sampling_r & ~usb_bus_reset;
		end
	end

endmodule // bps_top

/* File: verilog/bps_defines.svh */
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define BPS_CLK_MHZ 100
// settle time before a strap level is taken, in ns
`define BPS_STRAP_SETTLE_NS 1000
`define BPS_STRAP_CYC \
	((`BPS_STRAP_SETTLE_NS * `BPS_CLK_MHZ + 999) / 1000)
// i2c bus rate in kHz, one bit is four quarter phases
`define BPS_I2C_KHZ 100
`define BPS_I2C_QTR_CYC ((`BPS_CLK_MHZ * 1000) / (4 * `BPS_I2C_KHZ))

// ****************************************************************
// power limit
// ****************************************************************
`define BPS_LOWPWR_MAX 8'h32
`define BPS_POL_RST 1'b1

// ****************************************************************
// eeprom access and layout
// ****************************************************************
`define BPS_EE_ADDR_W 8'hA0
`define BPS_EE_ADDR_R 8'hA1
`define BPS_EE_START 8'h00
`define BPS_EE_BYTES 8
`define BPS_EE_VID_LO 0
`define BPS_EE_VID_HI 1
`define BPS_EE_PID_LO 2
`define BPS_EE_PID_HI 3
`define BPS_EE_ATTR 4
`define BPS_EE_MAXP 5
`define BPS_EE_SIG 7

// ****************************************************************
// configuration defaults and attribute fields
// ****************************************************************
`define BPS_ATTR_DEF 8'hA0
`define BPS_ATTR_BASE 8'h80
`define BPS_ATTR_SELF_BIT 6
`define BPS_ATTR_RWK_BIT 5
`define BPS_MAXP_DEF 8'h2F
`define BPS_ID_RST 16'h0000

`endif

/* File: verilog/bps_pkg.sv */
`include "bps_defines.svh"

package bps_pkg;

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		TS_STRAP = 3'b001,
		TS_EE = 3'b010,
		TS_RUN = 3'b100
	} bps_top_st_t;

	typedef enum logic [4:0] {
		I2_IDLE = 5'b00001,
		I2_START = 5'b00010,
		I2_BIT = 5'b00100,
		I2_RSTART = 5'b01000,
		I2_STOP = 5'b10000
	} bps_i2c_st_t;

endpackage

/* File: verilog/bps_i2c_rd.sv */
`timescale 1ns/1ps
`include "bps_defines.svh"

module bps_i2c_rd import bps_pkg::*; #(
	parameter int QTR_CYC = `BPS_I2C_QTR_CYC,
	parameter logic [7:0] SIG = 8'h5A // arbitrary signature value
) (
	// clock and control
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic start,
	// synchronised data line
	input wire logic sda_in,
	// open-drain enables, high pulls the line low
	output logic sda_oe,
	output logic scl_oe,
	// result
	output logic busy,
	output logic done,
	output logic ok,
	output logic [63:0] data
);

	// ************************************************************
	// state
	// ************************************************************
	bps_i2c_st_t st_r;
	logic [15:0] qcnt_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [3:0] step_r;
	logic [7:0] sh_r;
	logic nack_r;
	logic [7:0] mem [0:`BPS_EE_BYTES-1];
	logic tick;
	logic rd;
	logic last;

	// byte sent in each write step
	function automatic logic [7:0] tx_byte(input logic [3:0] s);
		case (s)
			4'h0: tx_byte = `BPS_EE_ADDR_W;
			4'h1: tx_byte = `BPS_EE_START;
			default: tx_byte = `BPS_EE_ADDR_R;
		endcase
	endfunction

	assign tick = (qcnt_r == 16'(QTR_CYC - 1));
	assign rd = (step_r >= 4'h3);
	assign last = (step_r == 4'hA);

	// flatten the byte store
	genvar gi;
	generate
		for (gi = 0; gi < `BPS_EE_BYTES; gi++) begin : g_data
			assign data[gi*8 +: 8] = mem[gi];
		end
	endgenerate

	// quarter-bit timer, runs only during a transfer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			qcnt_r <= 16'h0000;
		end else if (clk_en) begin
			if (st_r == I2_IDLE || tick)
				qcnt_r <= 16'h0000;
			else
				qcnt_r <= qcnt_r + 16'h0001;
		end
	end

	// transfer sequencer: write address, repeated start, read 8 bytes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= I2_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			step_r <= 4'h0;
			sh_r <= 8'h00;
			nack_r <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			ok <= 1'b0;
			for (int i = 0; i < `BPS_EE_BYTES; i++)
				mem[i] <= 8'h00;
		end else if (clk_en) begin
			done <= 1'b0;
			if (tick)
				ph_r <= ph_r + 2'h1;
			case (st_r)
				I2_IDLE: begin
					sda_oe <= 1'b0;
					scl_oe <= 1'b0;
					if (start) begin
						st_r <= I2_START;
						ph_r <= 2'h0;
						step_r <= 4'h0;
						bit_r <= 4'h0;
						nack_r <= 1'b0;
						sh_r <= tx_byte(4'h0);
						busy <= 1'b1;
					end
				end
				I2_START: if (tick) begin
					if (ph_r == 2'h1)
						sda_oe <= 1'b1;
					if (ph_r == 2'h2)
						scl_oe <= 1'b1;
					if (ph_r == 2'h3)
						st_r <= I2_BIT;
				end
				I2_BIT: if (tick) begin
					case (ph_r)
						2'h0: begin
							scl_oe <= 1'b1;
							if (bit_r == 4'h8)
								sda_oe <= rd & ~last; // ack all but the last
							else
								sda_oe <= rd ? 1'b0 : ~sh_r[7];
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: begin
							if (bit_r == 4'h8 && !rd && sda_in)
								nack_r <= 1'b1;
							if (bit_r != 4'h8 && rd)
								sh_r <= {sh_r[6:0], sda_in};
						end
						default: begin
							scl_oe <= 1'b1;
							if (bit_r != 4'h8) begin
								bit_r <= bit_r + 4'h1;
								if (!rd)
									sh_r <= {sh_r[6:0], 1'b0};
							end else begin
								bit_r <= 4'h0;
								if (rd)
									mem[3'(step_r - 4'h3)] <= sh_r;
								if (nack_r || last) begin
									st_r <= I2_STOP;
								end else if (step_r == 4'h1) begin
									st_r <= I2_RSTART;
								end else begin
									step_r <= step_r + 4'h1;
									sh_r <= tx_byte(step_r + 4'h1);
								end
							end
						end
					endcase
				end
				I2_RSTART: if (tick) begin
					case (ph_r)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b1;
						default: begin
							scl_oe <= 1'b1;
							step_r <= 4'h2;
							sh_r <= tx_byte(4'h2);
							st_r <= I2_BIT;
						end
					endcase
				end
				I2_STOP: if (tick) begin
					case (ph_r)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						default: begin
							st_r <= I2_IDLE;
							busy <= 1'b0;
							done <= 1'b1;
							ok <= ~nack_r & (mem[`BPS_EE_SIG] == SIG);
						end
					endcase
				end
				default: st_r <= I2_IDLE;
			endcase
		end
	end

endmodule // bps_i2c_rd

/* File: tb/bps_ee_model.sv */
`timescale 1ns/1ps

// ****
// serial eeprom partner, eight bytes, open drain
// ****
module bps_ee_model (
	// bus wires as seen on the board
	input wire logic sda,
	input wire logic scl,
	// stored bytes, byte 0 in the low bits
	input wire logic [63:0] image,
	// high pulls the data line low
	output logic oe
);
	logic act, first, rd;
	logic [3:0] bitc;
	logic [2:0] ptr;
	logic [7:0] sr;

	initial begin
		{act, first, rd, oe, bitc, ptr, sr} = '0;
	end
	// start and stop are data edges while the clock line is high
	always @(negedge sda) if (scl) begin
		act = 1;
		first = 1;
		bitc = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 0;
		rd = 0;
		oe = 0;
	end
	// take every bit the controller clocks, ack slot included
	always @(posedge scl) if (act) begin
		sr = {sr[6:0], sda};
		bitc = bitc + 4'h1;
	end
	// change the data line only while the clock line is low
	always @(negedge scl) if (act) begin
		if (bitc == 4'h8) begin
			oe = ~rd & (~first | (sr[7:1] == 7'h50));
			if (first) begin
				rd = sr[0];
				ptr = 0; // reads start at byte 0
			end else if (rd)
				ptr = ptr + 3'h1;
			first = 0;
		end else if (bitc == 4'h9) begin
			bitc = 0;
			if (rd && sr[0])
				rd = 0; // controller refused, stop sending
			oe = rd & ~image[8*ptr+7];
		end else if (rd)
			oe = ~image[8*ptr+7-bitc];
	end
endmodule // bps_ee_model

/* File: tb/bps_top_asserts.sv */
`timescale 1ns/1ps

// ****
// port checker for the power limit and strap logic
// ****
module bps_top_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// usb state
	input wire logic usb_suspend,
	input wire logic usb_configured,
	input wire logic usb_bus_reset,
	// pins
	input wire logic limit_pin_out,
	input wire logic limit_pin_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic scl_out,
	input wire logic scl_oe,
	// configuration
	input wire logic bus_power_limit_flag,
	input wire logic cfg_done,
	input wire logic eeprom_valid,
	input wire logic remote_wakeup_en,
	input wire logic self_powered,
	input wire logic [15:0] cfg_vendor_id,
	input wire logic [7:0] cfg_attr,
	input wire logic [7:0] cfg_max_power
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// power limit flag against usb state
	a_susp_limit: assert property (
		clk_en && usb_suspend |=> bus_power_limit_flag)
		else $error("limit flag low in suspend");
	a_low_free: assert property (
		clk_en && !usb_suspend && cfg_max_power <= 8'h32
		|=> !bus_power_limit_flag)
		else $error("low power device flagged while awake");
	a_high_unconf: assert property (
		clk_en && !usb_configured && cfg_max_power > 8'h32
		|=> bus_power_limit_flag)
		else $error("high power device not flagged");
	a_conf_free: assert property (
		clk_en && usb_configured && !usb_suspend
		|=> !bus_power_limit_flag)
		else $error("flag held after configuration");
	// polarity strap window and pin drive
	a_strap_float: assert property (
		clk_en && usb_bus_reset |=> !limit_pin_oe [*3])
		else $error("limit pin driven in strap window");
	a_pol_steady: assert property (
		limit_pin_oe && $past(limit_pin_oe)
		|-> $stable(limit_pin_out ^ bus_power_limit_flag))
		else $error("limit pin polarity moved");
	// open drain use and configuration result
	a_od_only: assert property (!sda_out && !scl_out)
		else $error("i2c line driven high");
	a_bus_free: assert property (
		cfg_done |-> !sda_oe && !scl_oe)
		else $error("i2c line held after configuration");
	a_cfg_hold: assert property (
		cfg_done |=> cfg_done && $stable(cfg_vendor_id)
		&& $stable(cfg_attr))
		else $error("configuration changed");
	a_attr_match: assert property (
		cfg_done |-> remote_wakeup_en == cfg_attr[5]
		&& self_powered == cfg_attr[6])
		else $error("attribute bits disagree");
	a_ee_valid: assert property (eeprom_valid |-> cfg_done)
		else $error("eeprom accepted before done");

	// main scenarios
	c_ee_ok: cover property (cfg_done && eeprom_valid);
	c_susp: cover property (usb_suspend && limit_pin_oe);
	c_brst: cover property (usb_bus_reset ##1 !limit_pin_oe);
endmodule // bps_top_asserts

bind bps_top bps_top_asserts u_chk (
	.ref_clk, .srst, .clk_en, .usb_suspend, .usb_configured,
	.usb_bus_reset, .limit_pin_out, .limit_pin_oe, .sda_out, .sda_oe,
	.scl_out, .scl_oe, .bus_power_limit_flag, .cfg_done, .eeprom_valid,
	.remote_wakeup_en, .self_powered, .cfg_vendor_id, .cfg_attr,
	.cfg_max_power
);

/* File: tb/bps_top_bench.sv */
`timescale 1ns/1ps

// ****
// bench for the power limit and strap logic
// ****
module bps_top_bench;
	logic ref_clk = 0, srst = 1, clk_en = 1;
	logic usb_suspend = 0, usb_configured = 0, usb_bus_reset = 0;
	logic sda_pu = 1, scl_pu = 1, lim_pu = 1;
	logic [63:0] image = '0;
	logic limit_pin_out, limit_pin_oe, sda_out, sda_oe, scl_out, scl_oe;
	logic bus_power_limit_flag, cfg_done, eeprom_valid;
	logic remote_wakeup_en, self_powered;
	logic [15:0] cfg_vendor_id, cfg_product_id;
	logic [7:0] cfg_attr, cfg_max_power;
	logic ee_oe, sda_w, scl_w, lim_w;
	logic ee_on = 1;
	int err_total = 0, checked = 0;

	always #5 ref_clk = ~ref_clk;
	// board wires: pull resistors, open drain i2c drivers, three-state limit pin driver
	// ee_on low takes the eeprom off the board, so nothing acks
	assign #1 sda_w = sda_pu & ~sda_oe & ~(ee_oe & ee_on);
	assign scl_w = scl_pu & ~scl_oe;
	assign lim_w = limit_pin_oe ? limit_pin_out : lim_pu;

	bps_top #(.STRAP_CYC(4), .QTR_CYC(4), .SIG(8'h5A),
		.VID_DEF(16'h1234), .PID_DEF(16'h5678)) DUT (
		.ref_clk, .srst, .clk_en, .usb_suspend, .usb_configured,
		.usb_bus_reset, .limit_pin_in(lim_w), .limit_pin_out,
		.limit_pin_oe, .sda_in(sda_w), .sda_out, .sda_oe,
		.scl_in(scl_w), .scl_out, .scl_oe, .bus_power_limit_flag,
		.cfg_done, .eeprom_valid, .remote_wakeup_en, .self_powered,
		.cfg_vendor_id, .cfg_product_id, .cfg_attr, .cfg_max_power);
	bps_ee_model EE (.sda(sda_w), .scl(scl_w), .image(image), .oe(ee_oe));

	// ****
	// shared tasks
	// ****
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: bit %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: value %h not %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// reset, then wait for configuration under a bound
	task automatic boot;
		int i;
		srst = 1;
		cyc(12);
		srst = 0;
		for (i = 0; i < 4000 && cfg_done !== 1'b1; i++)
			cyc(1);
		if (cfg_done !== 1'b1) begin
			err_total++;
			$display("Error at %0t: configuration hung", $time);
			give_verdict;
		end
		cyc(8);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_straps;
		int k;
		for (k = 0; k < 3; k++) begin
			sda_pu = k[1];
			scl_pu = k[0];
			boot;
			chk_bit(eeprom_valid, 1'b0);
			chk_bit(remote_wakeup_en, ~sda_pu);
			chk_bit(self_powered, scl_pu);
			chk_val({8'h00, cfg_attr}, {9'h001, scl_pu, ~sda_pu, 5'h00});
			chk_val(cfg_vendor_id, 16'h1234);
			chk_bit(sda_oe | scl_oe, 1'b0);
		end
	endtask
	task automatic t_low_power;
		cyc(1);
		chk_bit(bus_power_limit_flag, 1'b0);
		chk_bit(limit_pin_oe, 1'b1);
		// enable low freezes the flag although suspend arrives
		clk_en = 0;
		usb_suspend = 1;
		cyc(2);
		chk_bit(bus_power_limit_flag, 1'b0);
		clk_en = 1;
		cyc(1);
		chk_bit(bus_power_limit_flag, 1'b1);
		chk_bit(lim_w, 1'b1);
		usb_suspend = 0;
		cyc(1);
		chk_bit(lim_w, 1'b0);
	endtask
	task automatic t_ee(input logic [7:0] mp);
		sda_pu = 1;
		scl_pu = 1;
		image = {8'h5A, 8'h00, mp, 8'hE0, 16'h7B3E, 16'hC2A1};
		boot;
		chk_bit(eeprom_valid, 1'b1);
		chk_val(cfg_vendor_id, 16'hC2A1);
		chk_val(cfg_product_id, 16'h7B3E);
		chk_val({8'h00, cfg_max_power}, {8'h00, mp});
		chk_bit(remote_wakeup_en & self_powered, 1'b1);
		chk_bit(bus_power_limit_flag, mp > 8'h32);
		usb_configured = 1;
		cyc(1);
		chk_bit(bus_power_limit_flag, 1'b0);
		usb_suspend = 1;
		cyc(1);
		chk_bit(bus_power_limit_flag, 1'b1);
		usb_suspend = 0;
		usb_configured = 0;
		cyc(1);
	endtask
	task automatic t_ee_bad;
		image[63:56] = 8'hA5;
		boot;
		chk_bit(eeprom_valid, 1'b0);
		chk_val({8'h00, cfg_attr}, 16'h00C0);
		chk_val(cfg_product_id, 16'h5678);
	endtask
	// straps high but no eeprom: address nack, straps decide
	task automatic t_ee_none;
		ee_on = 0;
		boot;
		chk_bit(eeprom_valid, 1'b0);
		chk_bit(self_powered & ~remote_wakeup_en, 1'b1);
		chk_val({8'h00, cfg_attr}, 16'h00C0);
		chk_val(cfg_vendor_id, 16'h1234);
		chk_bit(sda_oe | scl_oe, 1'b0);
		ee_on = 1;
	endtask
	task automatic t_polarity;
		lim_pu = 0;
		usb_bus_reset = 1;
		cyc(1);
		usb_bus_reset = 0;
		chk_bit(limit_pin_oe, 1'b0);
		cyc(8);
		usb_suspend = 1;
		cyc(1);
		chk_bit(lim_w, 1'b0);
		usb_suspend = 0;
		usb_configured = 1;
		cyc(1);
		chk_bit(lim_w, 1'b1);
	endtask

	initial begin
		t_straps;
		t_low_power;
		t_ee(8'h33);
		t_ee(8'h32);
		t_ee_bad;
		t_ee_none;
		t_polarity;
		give_verdict;
	end
endmodule // bps_top_bench
